// ==== derp_pkg.sv ====
// Package for the debug event and reset strap pin logic.
// Assumes one core clock domain; pins arrive asynchronous to it.
package derp_pkg;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam int         EVT_PINS      = 4;
  localparam int         SYNC_STAGES   = 3;
  localparam int         XFER_BITS     = 3;
  localparam int         WIDE_BUS_BITS = 64;
  localparam int         NARROW_BUS_BITS = 32;
  localparam logic [3:0] DIR_RESET     = 4'h0;
  localparam logic [2:0] CODE_RESET    = 3'h0;
  localparam logic [7:0] CNT_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of per-pin input function selects
  // ----------------------------------------------------------------
  localparam int SEL_CHAN  = 0;
  localparam int SEL_EVENT = 1;
  localparam int SEL_EXTRA = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    derp_in_chan,
    derp_in_event,
    derp_in_extra,
    derp_in_off
  } derp_in_mode_t;

  typedef enum {
    derp_st_reset,
    derp_st_run
  } derp_state_t;

  typedef struct packed {
    logic debug_request;
    logic [3:0] chan_enable;
    logic [3:0] debug_event;
    logic counter_enable;
  } derp_in_fn_t;

  typedef struct packed {
    logic [3:0] chan_detect;
    logic debug_ack;
    logic ack_on_pin1;
    logic receive_read;
  } derp_out_src_t;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [2:0] bank;
  } derp_bus_info_t;

endpackage : derp_pkg

// ==== derp_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes ref_clk domain; output changes when stages two and three agree.
module derp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] st1;
  logic [WIDTH-1:0] st2;
  logic [WIDTH-1:0] st3;
  wire  [WIDTH-1:0] agree = ~(st2 ^ st3);
  wire  [WIDTH-1:0] next_level = (agree & st3) | (~agree & level);

  if (WIDTH < 1) begin : g_width_check
    $error("derp_sync width must be positive");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st1   <= '0;
      st2   <= '0;
      st3   <= '0;
      level <= '0;
    end else begin
      st1   <= pin;
      st2   <= st1;
      st3   <= st2;
      level <= next_level;
    end
  end

endmodule : derp_sync

// ==== derp_strap.sv ====
// Captures strap levels at each power-on reset release.
// Assumes straps already synchronised; por_active is a synchronous level.
module derp_strap (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic por_active,
  input  wire logic debug_mode_strap,
  input  wire logic host_port_strap,
  output logic      debug_mode,
  output logic      host_port_en,
  output logic      captured
);

  logic por_seen;
  wire  release_edge = por_seen & ~por_active;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_seen     <= 1'b1;
      debug_mode   <= 1'b0;
      host_port_en <= 1'b0;
      captured     <= 1'b0;
    end else begin
      por_seen <= por_active;
      if (release_edge) begin
        debug_mode   <= debug_mode_strap;
        host_port_en <= host_port_strap;
        captured     <= 1'b1;
      end else if (por_active) begin
        captured <= 1'b0;
      end
    end
  end

endmodule : derp_strap

// ==== derp_top.sv ====
// Debug event pins, reset straps, transfer code and bank select pins.
// Assumes core event logic on ref_clk; pins are asynchronous inputs.
// Functional notes
// - Debug mode strap sampled at reset release.
// - Host strap enables host port, 32-bit bus.
// - Four event pins default input, individually reconfigurable.
// - Pin 0 input: debug request, channel, event.
// - Pin 0 output: channel 0 detection.
// - Pin 1 input: channel 1 or event.
// - Pin 1 output: debug acknowledge or channel 1.
// - Pin 2 input: channel, event, or counter enable.
// - Pin 2 output: channel 2 detection.
// - Pin 3 input: channel 3 or event.
// - Pin 3 output: receive register was read.
// - Transfer code shows own bus transactions.
// - Same pins give SDRAM bank in pipelined mode.
module derp_top (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          power_on_reset_n,
  input  wire logic                          debug_mode_strap,
  input  wire logic                          host_port_strap,
  input  wire logic [derp_pkg::EVT_PINS-1:0] event_pin_in,
  output logic      [derp_pkg::EVT_PINS-1:0] event_pin_out,
  output logic      [derp_pkg::EVT_PINS-1:0] event_pin_oe,
  input  wire logic                          dir_write,
  input  wire logic [derp_pkg::EVT_PINS-1:0] dir_value,
  input  wire logic                          mode_write,
  input  wire derp_pkg::derp_in_mode_t       mode_value [4],
  input  wire logic                          ack_on_pin1,
  input  wire logic [3:0]                    chan_detect,
  input  wire logic                          debug_ack,
  input  wire logic                          debug_receive_reg_read,
  input  wire derp_pkg::derp_bus_info_t      bus_info,
  input  wire logic                          pipelined_bus_mode,
  input  wire logic                          event_count_tick,
  output derp_pkg::derp_in_fn_t              in_fn,
  output logic      [7:0]                    event_count,
  output logic                               debug_mode,
  output logic                               host_port_en,
  output logic                               bus_narrow,
  output logic                               host_config_pending,
  output logic                               xfer_code_0,
  output logic                               xfer_code_1,
  output logic                               xfer_code_2,
  output logic                               sdram_bank_sel_0,
  output logic                               sdram_bank_sel_1,
  output logic                               sdram_bank_sel_2
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (derp_pkg::EVT_PINS != 4) begin : g_pin_count
    $error("derp_top is wired for exactly four event pins");
  end

  if (derp_pkg::XFER_BITS != 3) begin : g_xfer_count
    $error("derp_top is wired for exactly three shared pins");
  end

  if (derp_pkg::SYNC_STAGES != 3) begin : g_sync_count
    $error("derp_top expects a three-stage synchroniser");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [derp_pkg::EVT_PINS+2:0] raw_pins;
  logic [derp_pkg::EVT_PINS+2:0] sync_pins;

  assign raw_pins = {power_on_reset_n, debug_mode_strap,
                     host_port_strap, event_pin_in};

  derp_sync #(
    .WIDTH (derp_pkg::EVT_PINS + 3)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (raw_pins),
    .level   (sync_pins)
  );

  wire                          por_active = ~sync_pins[6];
  wire                          dbg_strap_s = sync_pins[5];
  wire                          host_strap_s = sync_pins[4];
  wire [derp_pkg::EVT_PINS-1:0] pin_s = sync_pins[3:0];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic strap_done;
  logic strap_host;

  derp_strap u_strap (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .por_active       (por_active),
    .debug_mode_strap (dbg_strap_s),
    .host_port_strap  (host_strap_s),
    .debug_mode       (debug_mode),
    .host_port_en     (strap_host),
    .captured         (strap_done)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  derp_pkg::derp_state_t   state;
  derp_pkg::derp_state_t   next_state;
  derp_pkg::derp_in_mode_t mode [4];
  logic [derp_pkg::EVT_PINS-1:0] dir;

  wire run = (state == derp_pkg::derp_st_run);
  wire [3:0] run_mask = {4{run}};

  always_comb begin
    case (state)
      derp_pkg::derp_st_reset:
        next_state = strap_done ? derp_pkg::derp_st_run
                                : derp_pkg::derp_st_reset;
      derp_pkg::derp_st_run:
        next_state = por_active ? derp_pkg::derp_st_reset
                                : derp_pkg::derp_st_run;
      default:
        next_state = derp_pkg::derp_st_reset;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= derp_pkg::derp_st_reset;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dir <= derp_pkg::DIR_RESET;
    end else if (!run) begin
      dir <= derp_pkg::DIR_RESET;
    end else if (dir_write) begin
      dir <= dir_value;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        mode[i] <= derp_pkg::derp_in_chan;
      end
    end else if (!run) begin
      for (int i = 0; i < 4; i++) begin
        mode[i] <= derp_pkg::derp_in_chan;
      end
    end else if (mode_write) begin
      for (int i = 0; i < 4; i++) begin
        mode[i] <= mode_value[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input functions of event pins
  // ----------------------------------------------------------------
  function automatic logic pin_fn(input logic act,
                                  input derp_pkg::derp_in_mode_t m,
                                  input derp_pkg::derp_in_mode_t want);
    pin_fn = act & (m == want);
  endfunction : pin_fn

  wire [3:0] in_act = pin_s & ~dir & run_mask;
  derp_pkg::derp_in_fn_t next_in_fn;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_in_fn.chan_enable[i] =
        pin_fn(in_act[i], mode[i], derp_pkg::derp_in_chan);
      next_in_fn.debug_event[i] =
        pin_fn(in_act[i], mode[i], derp_pkg::derp_in_event);
    end
    // Pin 0 extra use
    next_in_fn.debug_request =
      pin_fn(in_act[0], mode[0], derp_pkg::derp_in_extra);
    // Pin 1 and 3 have channel and event only
    // Pin 2 extra use
    next_in_fn.counter_enable =
      pin_fn(in_act[2], mode[2], derp_pkg::derp_in_extra);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_fn <= '0;
    end else begin
      in_fn <= next_in_fn;
    end
  end

  wire count_step = in_fn.counter_enable & event_count_tick;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_count <= derp_pkg::CNT_RESET;
    end else if (!run) begin
      event_count <= derp_pkg::CNT_RESET;
    end else if (count_step) begin
      event_count <= event_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Output functions of event pins
  // ----------------------------------------------------------------
  logic [3:0] next_out;

  assign next_out[0] = chan_detect[0];
  assign next_out[1] = ack_on_pin1 ? debug_ack
                                   : chan_detect[1];
  assign next_out[2] = chan_detect[2];
  assign next_out[3] = debug_receive_reg_read;

  wire [3:0] drive_mask   = dir & run_mask;
  wire [3:0] next_pin_out = next_out & drive_mask;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_pin_out <= '0;
    end else begin
      event_pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_pin_oe <= '0;
    end else begin
      event_pin_oe <= drive_mask;
    end
  end

  // ----------------------------------------------------------------
  // Host port and bus width
  // ----------------------------------------------------------------
  wire host_live = strap_host & run;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_port_en <= 1'b0;
      bus_narrow   <= 1'b0;
    end else begin
      host_port_en <= host_live;
      bus_narrow   <= host_live;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_config_pending <= 1'b0;
    end else begin
      host_config_pending <= host_live;
    end
  end

  // ----------------------------------------------------------------
  // Transfer code and bank select pins
  // ----------------------------------------------------------------
  wire [2:0] next_code = (bus_info.valid && run) ? bus_info.code
                                                 : derp_pkg::CODE_RESET;
  wire [2:0] next_bank = run ? bus_info.bank : derp_pkg::CODE_RESET;
  wire [2:0] shared    = pipelined_bus_mode ? next_bank
                                            : next_code;

  wire [2:0] next_xfer_pins = shared & {3{~pipelined_bus_mode}};
  wire [2:0] next_bank_pins = shared & {3{pipelined_bus_mode}};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xfer_code_0 <= 1'b0;
      xfer_code_1 <= 1'b0;
      xfer_code_2 <= 1'b0;
    end else begin
      xfer_code_0 <= next_xfer_pins[0];
      xfer_code_1 <= next_xfer_pins[1];
      xfer_code_2 <= next_xfer_pins[2];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdram_bank_sel_0 <= 1'b0;
      sdram_bank_sel_1 <= 1'b0;
      sdram_bank_sel_2 <= 1'b0;
    end else begin
      sdram_bank_sel_0 <= next_bank_pins[0];
      sdram_bank_sel_1 <= next_bank_pins[1];
      sdram_bank_sel_2 <= next_bank_pins[2];
    end
  end

endmodule : derp_top

// ==== derp_properties.sv ====
// Assertion checker for derp_top pins and transfer outputs.
// Assumes binding to derp_top; rst is async and active high.
module derp_properties (
  input wire logic [3:0] event_pin_out,
  input wire logic [3:0] event_pin_oe,
  input wire logic [3:0] chan_detect,
  input wire logic [7:0] event_count,
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       power_on_reset_n,
  input wire logic       dir_write,
  input wire logic       ack_on_pin1,
  input wire logic       debug_ack,
  input wire logic       debug_receive_reg_read,
  input wire logic       pipelined_bus_mode,
  input wire logic       xfer_code_0,
  input wire logic       xfer_code_1,
  input wire logic       xfer_code_2,
  input wire logic       sdram_bank_sel_0,
  input wire logic       sdram_bank_sel_1,
  input wire logic       sdram_bank_sel_2,
  input wire derp_pkg::derp_bus_info_t bus_info,
  input wire derp_pkg::derp_in_fn_t    in_fn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Run tracking
  // ----------
  logic [3:0] run_cnt;
  wire        running = run_cnt == 4'hf;
  wire  [2:0] code_pins = {xfer_code_2, xfer_code_1, xfer_code_0};
  wire  [2:0] bank_pins = {sdram_bank_sel_2, sdram_bank_sel_1,
                           sdram_bank_sel_0};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      run_cnt <= 4'h0;
    else if (!power_on_reset_n)
      run_cnt <= 4'h0;
    else if (!running)
      run_cnt <= run_cnt + 4'h1;
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence por_held;
    !power_on_reset_n [*8];
  endsequence
  sequence oe_rise;
    (event_pin_oe & ~$past(event_pin_oe)) != 4'h0;
  endsequence
  pin02_out_a: assert property (
    (!event_pin_oe[0] || event_pin_out[0] == $past(chan_detect[0])) &&
    (!event_pin_oe[2] || event_pin_out[2] == $past(chan_detect[2])))
    else $error("pin 0 or 2 output wrong");
  pin1_out_a: assert property (
    event_pin_oe[1] |-> event_pin_out[1] == ($past(ack_on_pin1) ?
    $past(debug_ack) : $past(chan_detect[1])))
    else $error("pin 1 output wrong");
  pin3_out_a: assert property (
    event_pin_oe[3] |-> event_pin_out[3] == $past(debug_receive_reg_read))
    else $error("pin 3 output wrong");
  oe_cause_a: assert property (
    oe_rise |-> $past(dir_write, 2))
    else $error("enable rose without write");
  reset_quiet_a: assert property (
    por_held |-> event_pin_oe == 4'h0 && in_fn == '0 &&
    event_count == 8'h00)
    else $error("outputs active in reset");
  code_follow_a: assert property (
    running && bus_info.valid && !pipelined_bus_mode |=>
    code_pins == $past(bus_info.code))
    else $error("transfer code wrong");
  bank_on_a: assert property (
    running && pipelined_bus_mode |=> bank_pins == $past(bus_info.bank))
    else $error("bank select wrong");
  bank_off_a: assert property (
    !pipelined_bus_mode |=> bank_pins == 3'h0)
    else $error("bank select not idle");
  count_step_a: assert property (
    $changed(event_count) |->
    event_count == $past(event_count) + 8'h01 || event_count == 8'h00)
    else $error("counter jumped");
endmodule : derp_properties

bind derp_top derp_properties u_props (
  .ref_clk, .rst, .power_on_reset_n, .event_pin_out, .event_pin_oe,
  .dir_write, .ack_on_pin1, .chan_detect, .debug_ack,
  .debug_receive_reg_read, .bus_info, .pipelined_bus_mode, .in_fn,
  .event_count, .xfer_code_0, .xfer_code_1, .xfer_code_2,
  .sdram_bank_sel_0, .sdram_bank_sel_1, .sdram_bank_sel_2
);

// ==== derp_dbg_ext.sv ====
// Debug equipment and power-on reset model at the event pins.
// Assumes pin levels resolve from device enables and own drive.
module derp_dbg_ext (
  input  wire logic       por_req,
  input  wire logic [3:0] ext_level,
  input  wire logic [3:0] event_pin_out,
  input  wire logic [3:0] event_pin_oe,
  input  wire logic       host_config_pending,
  output logic            power_on_reset_n,
  output logic      [3:0] event_pin_in,
  output logic            config_written
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Pin resolution
  // ----------
  assign power_on_reset_n = !por_req;
  assign event_pin_in = (event_pin_oe & event_pin_out) |
                        (~event_pin_oe & ext_level);
  assign config_written = host_config_pending;
endmodule : derp_dbg_ext

// ==== tb.sv ====
// Self-checking bench for derp_top with the debug equipment model.
// Assumes 200 MHz ref_clk; event pins resolved by derp_dbg_ext.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Stimulus and results
  // ----------
  logic ref_clk = 1'b0, rst = 1'b1, por_req = 1'b1, ds = 1'b0;
  logic hs = 1'b0, dir_write = 1'b0, mode_write = 1'b0, ack1 = 1'b0;
  logic dack = 1'b0, rx_read = 1'b0, pipe = 1'b0, tick = 1'b0;
  logic [3:0] ext_level = 4'h0, dir_value = 4'h0, chan = 4'h0;
  derp_pkg::derp_bus_info_t bus_info = '0;
  derp_pkg::derp_in_mode_t mode_value [4] = '{default: derp_pkg::derp_in_off};
  wire por_n, dbg, host_en, narrow, pend, cfg;
  wire [3:0] pin_in, pin_out, pin_oe;
  wire [2:0] code, bank;
  wire [7:0] event_count;
  wire derp_pkg::derp_in_fn_t in_fn;
  derp_pkg::derp_in_fn_t f;
  int err_total = 0, tests_run = 0, cnt = 0, n;
  int modes [4];
  always #2.5 ref_clk = ~ref_clk;
  derp_top uut (.ref_clk, .rst, .power_on_reset_n(por_n),
    .debug_mode_strap(ds), .host_port_strap(hs), .event_pin_in(pin_in),
    .event_pin_out(pin_out), .event_pin_oe(pin_oe), .dir_write,
    .dir_value, .mode_write, .mode_value, .ack_on_pin1(ack1),
    .chan_detect(chan), .debug_ack(dack), .debug_receive_reg_read(rx_read),
    .bus_info, .pipelined_bus_mode(pipe), .event_count_tick(tick), .in_fn,
    .event_count, .debug_mode(dbg), .host_port_en(host_en),
    .bus_narrow(narrow), .host_config_pending(pend), .xfer_code_0(code[0]),
    .xfer_code_1(code[1]), .xfer_code_2(code[2]),
    .sdram_bank_sel_0(bank[0]), .sdram_bank_sel_1(bank[1]),
    .sdram_bank_sel_2(bank[2]));
  derp_dbg_ext ext (.por_req, .ext_level, .event_pin_out(pin_out),
    .event_pin_oe(pin_oe), .host_config_pending(pend),
    .power_on_reset_n(por_n), .event_pin_in(pin_in), .config_written(cfg));
  // ----------
  // Tasks
  // ----------
  task automatic chk_bits(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_bits
  task automatic chk_fn(input derp_pkg::derp_in_fn_t exp);
    tests_run++;
    if (in_fn !== exp) begin
      err_total++;
      $display("ERROR t=%0t in_fn got %h exp %h", $time, in_fn, exp);
    end
  endtask : chk_fn
  task automatic wait_n(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : wait_n
  task automatic set_dir(input logic [3:0] v);
    dir_value = v;
    dir_write = 1'b1;
    wait_n(1);
    dir_write = 1'b0;
    wait_n(2);
  endtask : set_dir
  task automatic set_modes();
    foreach (modes[i]) mode_value[i] = derp_pkg::derp_in_mode_t'(modes[i]);
    mode_write = 1'b1;
    wait_n(1);
    mode_write = 1'b0;
    wait_n(8);
  endtask : set_modes
  task automatic por_cycle(input logic dm, hp);
    por_req = 1'b1;
    ds = dm;
    hs = hp;
    wait_n(12);
    por_req = 1'b0;
    wait_n(20);
    ds = !dm;
    hs = !hp;
    wait_n(10);
    chk_bits(dbg, dm, "debug mode");
    chk_bits({host_en, narrow}, {hp, hp}, "host strap");
    chk_bits({pend, cfg}, {hp, hp}, "host config");
    chk_bits(pin_oe, 4'h0, "dir reset");
    cnt = 0;
  endtask : por_cycle
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ----------
  // Tests
  // ----------
  initial begin
    #100us;
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(64));
    wait_n(5);
    rst = 1'b0;
    for (int s = 0; s < 4; s++) por_cycle(s[0], s[1]);
    $display("test straps done");
    for (int r = 0; r < 16; r++) begin
      foreach (modes[i]) modes[i] = (r + i) % 4;
      ext_level = 4'($urandom);
      set_modes();
      f = '0;
      foreach (modes[i]) f.chan_enable[i] = ext_level[i] && modes[i] == 0;
      foreach (modes[i]) f.debug_event[i] = ext_level[i] && modes[i] == 1;
      f.debug_request = ext_level[0] && modes[0] == 2;
      f.counter_enable = ext_level[2] && modes[2] == 2;
      chk_fn(f);
    end
    $display("test inputs done");
    modes = '{3, 3, 2, 3};
    ext_level = 4'h4;
    set_modes();
    for (int r = 0; r < 2; r++) begin
      n = 1 + $urandom % 40;
      tick = 1'b1;
      wait_n(n);
      tick = 1'b0;
      wait_n(2);
      cnt += (r == 0) ? n : 0;
      chk_bits(event_count, 8'(cnt), "count");
      ext_level = 4'h0;
      wait_n(8);
    end
    $display("test counter done");
    set_dir(4'hf);
    chk_bits(pin_oe, 4'hf, "dir set");
    for (int r = 0; r < 24; r++) begin
      {ack1, dack, rx_read, chan} = 7'($urandom);
      wait_n(1);
      chk_bits(pin_out, {rx_read, chan[2], ack1 ? dack : chan[1], chan[0]},
               "pin out");
    end
    set_modes();
    chk_bits(pin_oe, 4'hf, "dir held");
    set_dir(4'h5);
    chk_bits(pin_oe, 4'h5, "dir each");
    $display("test outputs done");
    for (int r = 0; r < 32; r++) begin
      bus_info = 7'($urandom);
      pipe = 1'($urandom);
      wait_n(1);
      chk_bits(bank, pipe ? bus_info.bank : 3'h0, "bank");
      chk_bits(code, (bus_info.valid && !pipe) ? bus_info.code : 3'h0,
               "code");
    end
    $display("test transfer done");
    por_cycle(1'b1, 1'b0);
    $display("test late reset done");
    summarize();
  end
endmodule : tb
